// File: design/isdn_interrupt_aggregator.sv
/*
 Interrupt aggregation for the ISDN S/T controller: main status and mask,
 extended status, buffered code receive registers and monitor status.
 Assumes a decoded one-cycle read/write strobe port and event sources on clk_i.
*/
`include "isdn_irq_defines.svh"

module isdn_interrupt_aggregator (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire isdn_irq_pkg::reg_req_t bus_i,
    output logic [7:0] rdata_o,
    input wire isdn_irq_pkg::main_evt_t main_evt_i,
    input wire isdn_irq_pkg::ext_evt_t ext_evt_i,
    input wire isdn_irq_pkg::code_in_t sq_code_i,
    input wire isdn_irq_pkg::code_in_t ch0_code_i,
    input wire isdn_irq_pkg::code_in_t ch1_code_i,
    input wire isdn_irq_pkg::mon_in_t [1:0] mon_i,
    output logic irq_request_pin_low_o
);

    // Register strobes
    logic rd_main;
    logic rd_ext;
    logic rd_code_zero;
    logic rd_code_one;
    logic rd_sq;
    logic rd_mon_status;
    logic wr_mask;
    logic wr_sq;
    logic wr_mon_ctrl;

    assign rd_main = bus_i.rd && (bus_i.addr == `ADDR_MAIN_STATUS);
    assign rd_ext = bus_i.rd && (bus_i.addr == `ADDR_EXT_STATUS);
    assign rd_code_zero = bus_i.rd && (bus_i.addr == `ADDR_CODE_RX_ZERO);
    assign rd_code_one = bus_i.rd && (bus_i.addr == `ADDR_CODE_RX_ONE);
    assign rd_sq = bus_i.rd && (bus_i.addr == `ADDR_SQ_REG);
    assign rd_mon_status = bus_i.rd && (bus_i.addr == `ADDR_MON_STATUS);
    assign wr_mask = bus_i.wr && (bus_i.addr == `ADDR_MAIN_STATUS);
    assign wr_sq = bus_i.wr && (bus_i.addr == `ADDR_SQ_REG);
    assign wr_mon_ctrl = bus_i.wr && (bus_i.addr == `ADDR_MON_STATUS);

    // Software-written control
    logic [7:0] interrupt_mask;
    logic [7:0] sq_transmit_reg;
    logic [7:0] mon_ctrl;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            interrupt_mask <= `MASK_RESET;
        end else if (wr_mask) begin
            interrupt_mask <= bus_i.wdata;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            sq_transmit_reg <= `SQ_TX_RESET;
        end else if (wr_sq) begin
            sq_transmit_reg <= bus_i.wdata;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            mon_ctrl <= `MON_CTRL_RESET;
        end else if (wr_mon_ctrl) begin
            mon_ctrl <= bus_i.wdata;
        end
    end

    // Code receive channels: 0 S/Q, 1 channel 0, 2 channel 1
    isdn_irq_pkg::code_in_t code_in [3];
    logic [2:0] code_read;
    logic [5:0] code_cur [3];
    logic [2:0] code_flag;
    logic [2:0] code_enable;
    logic sq_change_flag;
    logic ch0_code_change_flag;
    logic ch1_code_change_flag;
    logic code_change_summary_bit;

    assign code_in[0] = sq_code_i;
    assign code_in[1] = ch0_code_i;
    assign code_in[2] = ch1_code_i;
    assign code_read = {rd_code_one, rd_code_zero, rd_sq};

    assign code_enable = {sq_transmit_reg[`BIT_CH1_CHANGE_EN], 1'b1,
                          sq_transmit_reg[`BIT_SQ_CHANGE_EN]};
    assign sq_change_flag = code_flag[0] & code_enable[0];
    assign ch0_code_change_flag = code_flag[1];
    assign ch1_code_change_flag = code_flag[2] & code_enable[2];

    // Summary of the three change flags
    assign code_change_summary_bit = sq_change_flag | ch0_code_change_flag
                                     | ch1_code_change_flag;

    for (genvar i = 0; i < 3; i++) begin : g_code
        logic [5:0] held;
        logic held_valid;
        logic unread;
        logic [5:0] latest;
        logic new_code;
        logic load;

        assign latest = held_valid ? held : code_cur[i];
        assign new_code = code_in[i].valid && (code_in[i].code != latest);
        // Load only once old code read
        assign load = (code_read[i] && held_valid)
                      || (new_code && (!unread || code_read[i]));

        always_ff @(posedge clk_i) begin
            if (!rst_n_i) begin
                code_cur[i] <= 6'h00;
                held <= 6'h00;
                held_valid <= 1'b0;
                unread <= 1'b0;
            end else if (code_read[i] && held_valid) begin
                code_cur[i] <= held;
                unread <= 1'b1;
                held_valid <= new_code;
                if (new_code) begin
                    held <= code_in[i].code;
                end
            end else if (new_code && unread && !code_read[i]) begin
                held <= code_in[i].code;
                held_valid <= 1'b1;
            end else if (new_code) begin
                code_cur[i] <= code_in[i].code;
                unread <= 1'b1;
            end else if (code_read[i]) begin
                unread <= 1'b0;
            end
        end

        // Flags cleared by register zero read
        always_ff @(posedge clk_i) begin
            if (!rst_n_i) begin
                code_flag[i] <= 1'b0;
            end else if (load) begin
                code_flag[i] <= 1'b1;
            end else if (rd_code_zero) begin
                code_flag[i] <= 1'b0;
            end
        end
    end

    // Monitor channels
    logic [3:0] mon_bits [2];
    logic [7:0] mon_data [2];
    logic [1:0] mon_new;

    for (genvar c = 0; c < 2; c++) begin : g_mon
        logic mx_q;
        logic in_packet;
        logic byte_rx;
        logic rx_en;
        logic rx_ctrl;
        logic tx_en;
        logic take_byte;
        logic [3:0] sets;

        assign rx_en = mon_ctrl[4 * c + 3];
        assign rx_ctrl = mon_ctrl[4 * c + 2];
        assign tx_en = mon_ctrl[4 * c + 1];
        assign byte_rx = mx_q && !mon_i[c].monitor_handshake_bit;
        // First byte only without control enable
        assign take_byte = byte_rx && rx_en && (rx_ctrl || !in_packet);
        assign sets = {take_byte, mon_i[c].eor && rx_en,
                       mon_i[c].ack && tx_en, mon_i[c].abort && tx_en};
        assign mon_new[c] = |sets;

        always_ff @(posedge clk_i) begin
            if (!rst_n_i) begin
                mx_q <= 1'b1;
            end else begin
                mx_q <= mon_i[c].monitor_handshake_bit;
            end
        end

        always_ff @(posedge clk_i) begin
            if (!rst_n_i) begin
                in_packet <= 1'b0;
            end else if (mon_i[c].eor || mon_i[c].abort) begin
                in_packet <= 1'b0;
            end else if (byte_rx) begin
                in_packet <= 1'b1;
            end
        end

        always_ff @(posedge clk_i) begin
            if (!rst_n_i) begin
                mon_data[c] <= 8'h00;
            end else if (take_byte) begin
                mon_data[c] <= mon_i[c].data;
            end
        end

        // Read clears, new event wins
        always_ff @(posedge clk_i) begin
            if (!rst_n_i) begin
                mon_bits[c] <= 4'h0;
            end else begin
                mon_bits[c] <= (rd_mon_status ? 4'h0 : mon_bits[c]) | sets;
            end
        end
    end

    // Extended status
    logic [7:0] extended_irq_status;
    logic [7:0] ext_set;
    logic extended_summary_bit;

    // Extended sources, monitor in its own bit
    always_comb begin
        ext_set = {ext_evt_i.xmr, ext_evt_i.xdu, ext_evt_i.pce, ext_evt_i.rfo,
                   ext_evt_i.sov, 1'b0, ext_evt_i.saw, ext_evt_i.wov};
        ext_set[`BIT_MON_SOURCE] = |mon_new;
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            extended_irq_status <= 8'h00;
        end else begin
            extended_irq_status <= (rd_ext ? 8'h00 : extended_irq_status) | ext_set;
        end
    end

    assign extended_summary_bit = |extended_irq_status;

    // Main status
    logic [7:0] main_pending;
    logic [7:0] main_set;
    logic [7:0] main_clear;
    logic [7:0] main_irq_status;
    logic [7:0] main_visible;

    assign main_set = {main_evt_i.rme, main_evt_i.rpf, main_evt_i.rsc, main_evt_i.xpr,
                       main_evt_i.tin, 1'b0, main_evt_i.sin, 1'b0};

    always_comb begin
        main_irq_status = main_pending;
        main_irq_status[`BIT_EXT_SUMMARY] = extended_summary_bit;
        main_irq_status[`BIT_CODE_SUMMARY] = code_change_summary_bit;
    end

    assign main_visible = (main_irq_status & ~interrupt_mask)
                          | (main_irq_status & `SUMMARY_BITS);

    assign main_clear = rd_main ? (~interrupt_mask & ~`SUMMARY_BITS) : 8'h00;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            main_pending <= 8'h00;
        end else begin
            main_pending <= (main_pending & ~main_clear) | main_set;
        end
    end

    // OR of unmasked bits, low active
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            irq_request_pin_low_o <= 1'b1;
        end else begin
            // Level held while any unmasked bit set
            irq_request_pin_low_o <= ~|(main_irq_status & ~interrupt_mask);
        end
    end

    // Read data
    logic [7:0] next_rdata;
    logic mx_one_q;

    always_comb begin
        unique case (bus_i.addr)
            `ADDR_MAIN_STATUS: next_rdata = main_visible;
            `ADDR_EXT_STATUS: next_rdata = extended_irq_status;
            `ADDR_CODE_RX_ZERO: next_rdata = {sq_change_flag, 1'b0, code_cur[1][3:0],
                                              ch0_code_change_flag, ch1_code_change_flag};
            `ADDR_MON_RX_ZERO: next_rdata = mon_data[0];
            `ADDR_CODE_RX_ONE: next_rdata = {code_cur[2],
                                             mon_i[1].monitor_handshake_bit, mx_one_q};
            `ADDR_MON_RX_ONE: next_rdata = mon_data[1];
            `ADDR_MON_STATUS: next_rdata = {mon_bits[1], mon_bits[0]};
            `ADDR_SQ_REG: next_rdata = {sq_transmit_reg[7:6],
                                        sq_transmit_reg[`BIT_CH1_CHANGE_EN], 1'b0,
                                        code_cur[0][3:0]};
            default: next_rdata = `READ_IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            mx_one_q <= 1'b1;
        end else begin
            mx_one_q <= mon_i[1].monitor_handshake_bit;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            rdata_o <= `READ_IDLE;
        end else if (bus_i.rd) begin
            rdata_o <= next_rdata;
        end
    end

endmodule

// File: design/isdn_irq_defines.svh
/*
 Register offsets, field positions and reset values of the interrupt aggregator.
 Assumes inclusion by bare name from the design folder.
*/
`ifndef ISDN_IRQ_DEFINES_SVH
`define ISDN_IRQ_DEFINES_SVH

// Register offsets on the 8-bit processor port
`define ADDR_MAIN_STATUS 8'h20
`define ADDR_EXT_STATUS 8'h24
`define ADDR_CODE_RX_ZERO 8'h31
`define ADDR_MON_RX_ZERO 8'h32
`define ADDR_CODE_RX_ONE 8'h33
`define ADDR_MON_RX_ONE 8'h34
`define ADDR_MON_STATUS 8'h3a
`define ADDR_SQ_REG 8'h3b

// Main status bits that summarise other registers
`define BIT_EXT_SUMMARY 0
`define BIT_CODE_SUMMARY 2
`define SUMMARY_BITS 8'h05

// Enable bits of the S/Q transmit register
`define BIT_SQ_CHANGE_EN 4
`define BIT_CH1_CHANGE_EN 5

// Extended register bit of the monitor status source
`define BIT_MON_SOURCE 2

// Reset values
`define MASK_RESET 8'h00
`define SQ_TX_RESET 8'h00
`define MON_CTRL_RESET 8'h00
`define READ_IDLE 8'h00

`endif

// File: design/isdn_irq_pkg.sv
/*
 Carrier types of the interrupt aggregator.
 Assumes all producers run on the aggregator clock.
*/
package isdn_irq_pkg;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic rme;
        logic rpf;
        logic rsc;
        logic xpr;
        logic tin;
        logic sin;
    } main_evt_t;

    typedef struct packed {
        logic xmr;
        logic xdu;
        logic pce;
        logic rfo;
        logic sov;
        logic saw;
        logic wov;
    } ext_evt_t;

    typedef struct packed {
        logic valid;
        logic [5:0] code;
    } code_in_t;

    typedef struct packed {
        logic monitor_handshake_bit;
        logic [7:0] data;
        logic eor;
        logic ack;
        logic abort;
    } mon_in_t;

endpackage

// File: tb/isdn_irq_chk.sv
/*
 Port checker for the interrupt aggregator.
 Assumes the top's one-clock bus and event timing.
*/
module isdn_irq_chk (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire isdn_irq_pkg::reg_req_t bus_i,
    input wire logic [7:0] rdata_o,
    input wire isdn_irq_pkg::main_evt_t main_evt_i,
    input wire logic irq_request_pin_low_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] mask_q;
    logic rd_main;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    assign rd_main = bus_i.rd && bus_i.addr == 8'h20;
    // Copy of the mask
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            mask_q <= 8'h00;
        end else if (bus_i.wr && bus_i.addr == 8'h20) begin
            mask_q <= bus_i.wdata;
        end
    end
    a_reset_idle: assert property (disable iff (1'b0) !rst_n_i |=> irq_request_pin_low_o)
        else $error("request active after reset");
    a_event_request: assert property (main_evt_i.xpr && !mask_q[4] && !bus_i.rd
        && !bus_i.wr ##1 !bus_i.rd |=> !irq_request_pin_low_o)
        else $error("unmasked event gave no request");
    a_unmapped_zero: assert property (bus_i.rd && !(bus_i.addr inside {8'h20, 8'h24,
        [8'h31:8'h34], 8'h3a, 8'h3b}) |=> rdata_o == 8'h00) else $error("unmapped read not zero");
    a_rdata_hold: assert property (!bus_i.rd |=> $stable(rdata_o))
        else $error("read data moved");
    a_masked_hidden: assert property (rd_main |=> (rdata_o & $past(mask_q) & 8'hfa) == 8'h00)
        else $error("masked bit visible");
    a_masked_quiet: assert property (mask_q == 8'hff [*3] |-> irq_request_pin_low_o)
        else $error("request while all masked");
    a_read_clears: assert property (rd_main && main_evt_i == '0 ##1 rd_main
        && main_evt_i == '0 |=> (rdata_o & ~$past(mask_q) & 8'hfa) == 8'h00)
        else $error("status not cleared");
    a_request_holds: assert property (!bus_i.rd && !bus_i.wr ##1 !irq_request_pin_low_o
        && !bus_i.rd && !bus_i.wr |=> !irq_request_pin_low_o) else $error("request dropped");
endmodule
bind isdn_interrupt_aggregator isdn_irq_chk chk (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .bus_i(bus_i), .rdata_o(rdata_o), .main_evt_i(main_evt_i),
    .irq_request_pin_low_o(irq_request_pin_low_o));

// File: tb/isdn_cpu_model.sv
/*
 Processor model on the aggregator register port.
 Assumes tasks are called between clock edges.
*/
module isdn_cpu_model (
    input wire logic clk_i,
    input wire logic [7:0] rdata_i,
    output isdn_irq_pkg::reg_req_t bus_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial bus_o = '0;
    task automatic rd(input logic [7:0] a, input bit two, output logic [7:0] d0, d1);
        @(negedge clk_i);
        bus_o = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
        @(negedge clk_i);
        d0 = rdata_i;
        if (two) begin
            @(negedge clk_i);
        end
        d1 = rdata_i;
        bus_o = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: 8'hff};
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_i);
        bus_o = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
        @(negedge clk_i);
        bus_o = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
    endtask
    task automatic service_end(input logic [7:0] old_mask);
        wr(8'h20, 8'hff);
        repeat (3) @(negedge clk_i);
        wr(8'h20, old_mask);
    endtask
endmodule

// File: tb/tb.sv
/*
 Self-checking bench for the interrupt aggregator.
 Assumes the processor model drives the register port.
*/
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    isdn_irq_pkg::reg_req_t bus;
    logic [7:0] rdata;
    isdn_irq_pkg::main_evt_t main_evt = '0;
    isdn_irq_pkg::ext_evt_t ext_evt = '0;
    isdn_irq_pkg::code_in_t sq_code = '0;
    isdn_irq_pkg::code_in_t ch0_code = '0;
    isdn_irq_pkg::code_in_t ch1_code = '0;
    isdn_irq_pkg::mon_in_t [1:0] mon = {2{12'h800}};
    logic irq_n;
    int num_errors = 0;
    int checked = 0;
    isdn_interrupt_aggregator i_isdn_interrupt_aggregator (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .bus_i(bus), .rdata_o(rdata), .main_evt_i(main_evt), .ext_evt_i(ext_evt),
        .sq_code_i(sq_code), .ch0_code_i(ch0_code), .ch1_code_i(ch1_code), .mon_i(mon),
        .irq_request_pin_low_o(irq_n));
    isdn_cpu_model cpu (.clk_i(clk_i), .rdata_i(rdata), .bus_o(bus));
    initial begin
        forever #25 clk_i = ~clk_i;
    end
    task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic rd_chk(input logic [7:0] a, input bit two, input logic [7:0] e0, e1);
        logic [7:0] g0, g1;
        cpu.rd(a, two, g0, g1);
        cmp($sformatf("reg %h", a), e0, g0);
        if (two) begin
            cmp($sformatf("reg %h again", a), e1, g1);
        end
    endtask
    task automatic req(input logic e);
        @(negedge clk_i);
        cmp("request", {7'h00, e}, {7'h00, irq_n});
    endtask
    task automatic pulse(input int k, input logic [7:0] v);
        @(negedge clk_i);
        case (k)
            0: main_evt = v[5:0];
            1: ext_evt = v[6:0];
            2: ch0_code = {1'b1, v[5:0]};
            4: {mon[0].eor, mon[0].ack, mon[0].abort} = v[2:0];
            5: ch1_code = {1'b1, v[5:0]};
            default: sq_code = {1'b1, v[5:0]};
        endcase
        @(negedge clk_i);
        main_evt = '0;
        ext_evt = '0;
        ch0_code.valid = 1'b0;
        ch1_code.valid = 1'b0;
        sq_code.valid = 1'b0;
        {mon[0].eor, mon[0].ack, mon[0].abort} = 3'h0;
    endtask
    // Handshake idles high, falls to mark a byte
    task automatic mon_byte(input logic [7:0] d);
        @(negedge clk_i);
        mon[0].data = d;
        mon[0].monitor_handshake_bit = 1'b0;
        repeat (2) @(negedge clk_i);
        mon[0].monitor_handshake_bit = 1'b1;
        repeat (3) @(negedge clk_i);
    endtask
    task automatic final_report;
        $display("errors %0d checks %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge clk_i);
        num_errors++;
        final_report();
    end
    initial begin
        repeat (8) @(negedge clk_i);
        rst_n_i = 1'b1;
        req(1'b1);
        pulse(0, 8'h3f);
        req(1'b0);
        rd_chk(8'h20, 1, 8'hfa, 8'h00);
        req(1'b1);
        cpu.wr(8'h20, 8'h10);
        pulse(0, 8'h04);
        req(1'b1);
        rd_chk(8'h20, 1, 8'h00, 8'h00);
        cpu.wr(8'h20, 8'h00);
        req(1'b0);
        rd_chk(8'h20, 0, 8'h10, 8'h00);
        cpu.wr(8'h20, 8'h01);
        pulse(1, 8'h7f);
        repeat (2) @(negedge clk_i);
        req(1'b1);
        rd_chk(8'h20, 1, 8'h01, 8'h01);
        rd_chk(8'h24, 1, 8'hfb, 8'h00);
        rd_chk(8'h20, 0, 8'h00, 8'h00);
        cpu.wr(8'h20, 8'h00);
        pulse(2, 8'h05);
        pulse(2, 8'h09);
        pulse(2, 8'h0c);
        req(1'b0);
        rd_chk(8'h20, 1, 8'h04, 8'h04);
        rd_chk(8'h31, 1, 8'h16, 8'h32);
        rd_chk(8'h20, 0, 8'h00, 8'h00);
        pulse(3, 8'h03);
        rd_chk(8'h31, 0, 8'h30, 8'h00);
        rd_chk(8'h3b, 0, 8'h03, 8'h00);
        cpu.wr(8'h3b, 8'h10);
        pulse(3, 8'h06);
        rd_chk(8'h31, 0, 8'hb0, 8'h00);
        mon_byte(8'h5a);
        rd_chk(8'h3a, 0, 8'h00, 8'h00);
        cpu.wr(8'h3a, 8'h0c);
        mon_byte(8'ha5);
        rd_chk(8'h3a, 0, 8'h08, 8'h00);
        rd_chk(8'h32, 0, 8'ha5, 8'h00);
        cpu.service_end(8'h00);
        req(1'b0);
        rd_chk(8'h24, 0, 8'h04, 8'h00);
        rd_chk(8'h25, 0, 8'h00, 8'h00);
        req(1'b1);
        cpu.wr(8'h3b, 8'h20);
        pulse(5, 8'h2a);
        rd_chk(8'h31, 0, 8'h31, 8'h00);
        rd_chk(8'h33, 0, 8'hab, 8'h00);
        cpu.wr(8'h3a, 8'h0a);
        pulse(4, 8'h04);
        mon_byte(8'h11);
        rd_chk(8'h3a, 0, 8'h0c, 8'h00);
        mon_byte(8'h22);
        pulse(4, 8'h03);
        rd_chk(8'h3a, 0, 8'h03, 8'h00);
        rd_chk(8'h32, 0, 8'h11, 8'h00);
        rd_chk(8'h24, 0, 8'h04, 8'h00);
        req(1'b1);
        final_report();
    end
endmodule
